// ### hw/dadc_core.sv
// Purpose: dual converter result shifter, echo clock and nap/sleep control
// Assumes: readout clock and strobe sampled by ref_clk; conversion data arrive
//   as parallel words from the analog core on the same clock
// Notes: slow link clocks only; the echo follows the sampled readout clock

// Notes on behaviour
// - falling readout edge shifts next bit, msb first
// - echo clock matched in skew to data; here the echo leads the data by one ref_clk
// - complement echo tied high disables echo; here only in single-ended mode, differential mode ignores the tie
// - two strobes, clock idle, enter nap
// - nap begins at second strobe rising edge
// - readout rising edge leaves nap, else persists
// - nap exit needs no power-up wait
// - two more idle strobes move nap to sleep
// - single-ended mode: readout rising edge leaves sleep
// - differential mode: fifth strobe leaves sleep
// - fifth strobe wake also works single-ended
// - readout activity after wake blocks nap
// - idle strobes cycle oper, nap, sleep forever
// - select pin chooses single-ended or differential
// - single-ended: negative pins unused, pulled down
// - differential: drive both legs of outputs
// - strobe rise tracks, fall holds and converts
// - readout gives previous conversion result
module dadc_core #(
  parameter int unsigned RESULT_W = dadc_pkg::RESULT_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic convert_strobe,
  input wire logic readout_clk_p,
  input wire logic readout_clk_n,
  input wire logic iface_select,
  input wire logic echo_clock_n_tied,
  input wire logic [RESULT_W-1:0] chan_one_result,
  input wire logic [RESULT_W-1:0] chan_two_result,
  input wire logic results_valid,
  output logic channel_one_serial_out_p,
  output logic channel_one_serial_out_n,
  output logic channel_two_serial_out_p,
  output logic channel_two_serial_out_n,
  output logic echo_clock_out_p,
  output logic echo_clock_out_n,
  output logic sample_track,
  output logic convert_start,
  output logic nap_active,
  output logic sleep_active
);

  logic cnv_level;
  logic cnv_rise;
  logic cnv_fall;
  logic sck_p_level;
  logic sck_p_rise;
  logic sck_p_fall;
  logic sck_n_level;
  logic iface_level;
  logic tie_level;
  logic diff_mode;
  logic sck_level;
  logic sck_rise;
  logic sck_fall;
  // lane 0 is channel one, lane 1 is channel two
  logic [RESULT_W-1:0] lane_result [2];
  logic [RESULT_W-1:0] lane_held [2];
  logic [RESULT_W-1:0] lane_shift [2];
  logic lane_serial [2];
  logic lane_data_p [2];
  logic lane_data_n [2];
  logic [dadc_pkg::PULSE_CNT_W-1:0] idle_pulses;
  logic [dadc_pkg::PULSE_CNT_W-1:0] next_idle_pulses;
  logic echo_enable;
  dadc_pkg::dadc_power_e power;
  dadc_pkg::dadc_power_e next_power;

  // pin to pad takes about four ref_clk edges: two sync flops, the edge
  // flop, then the output register; pin pulses under two periods can be
  // missed, so this path suits slow readout clocks only
  // pins from the host pass two flops before any logic
  dadc_sync u_sync_cnv (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(convert_strobe),
    .level(cnv_level),
    .rise(cnv_rise),
    .fall(cnv_fall)
  );

  // readout clock, positive leg
  dadc_sync u_sync_sck_p (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(readout_clk_p),
    .level(sck_p_level),
    .rise(sck_p_rise),
    .fall(sck_p_fall)
  );

  // negative leg: only its level matters, and only in differential mode
  dadc_sync u_sync_sck_n (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(readout_clk_n),
    .level(sck_n_level),
    .rise(),
    .fall()
  );

  // mode pin is static in use but synchronised all the same
  dadc_sync u_sync_iface (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(iface_select),
    .level(iface_level),
    .rise(),
    .fall()
  );

  // echo tie strap, read as a level
  dadc_sync u_sync_tie (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(echo_clock_n_tied),
    .level(tie_level),
    .rise(),
    .fall()
  );

  // interface mode follows the select pin
  assign diff_mode = (iface_level == dadc_pkg::IFACE_DIFF);

  // in differential mode the clock is the pair's difference; single-ended
  // ignores the negative leg, which is pulled down off chip
  assign sck_level = diff_mode ? (sck_p_level & ~sck_n_level) : sck_p_level;
  assign sck_rise = diff_mode ? (sck_p_rise & ~sck_n_level) : sck_p_rise;
  assign sck_fall = diff_mode ? (sck_p_fall & sck_n_level) : sck_p_fall;

  // echo only runs in single-ended mode when the complement pin is free;
  // the tie check has no meaning once the pair is differential
  assign echo_enable = diff_mode | ~tie_level;

  // sampler tracks from strobe rise until strobe fall
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sample_track <= 1'b0;
    end else if (cnv_rise) begin
      sample_track <= 1'b1;
    end else if (cnv_fall) begin
      sample_track <= 1'b0;
    end
  end

  // one-cycle start pulse as the sampler goes to hold
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      convert_start <= 1'b0;
    end else begin
      convert_start <= cnv_fall;
    end
  end

  // channel words enter the lanes by index
  assign lane_result[0] = chan_one_result;
  assign lane_result[1] = chan_two_result;

  // one lane per channel; both lanes use the same edges, so the words
  // leave in lockstep and the echo leads either of them by one ref_clk
  for (genvar ch = 0; ch < 2; ch++) begin : g_lane
    // the word handed over now waits for the next strobe fall, so
    // readout always returns the previous conversion
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        lane_held[ch] <= dadc_pkg::RESULT_RESET;
      end else if (results_valid) begin
        lane_held[ch] <= lane_result[ch];
      end
    end

    // load on strobe fall, shift on readout fall; a load wins over a
    // shift in the same cycle so a late edge cannot skip the msb
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        lane_shift[ch] <= dadc_pkg::RESULT_RESET;
      end else if (cnv_fall) begin
        lane_shift[ch] <= lane_held[ch];
      end else if (sck_fall) begin
        lane_shift[ch] <= {lane_shift[ch][RESULT_W-2:0], 1'b0};
      end
    end

    // bit on the line: msb right after the load, then one per falling
    // edge; edges past the end of the word shift in zeros
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        lane_serial[ch] <= 1'b0;
      end else if (cnv_fall) begin
        lane_serial[ch] <= lane_held[ch][RESULT_W-1];
      end else if (sck_fall) begin
        lane_serial[ch] <= lane_shift[ch][RESULT_W-2];
      end
    end

    // positive leg carries the bit in both modes
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        lane_data_p[ch] <= 1'b0;
      end else begin
        lane_data_p[ch] <= lane_serial[ch];
      end
    end

    // negative leg is the complement in differential mode and held low
    // single-ended, like the pull-down on an open pin
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        lane_data_n[ch] <= 1'b0;
      end else begin
        lane_data_n[ch] <= diff_mode & ~lane_serial[ch];
      end
    end
  end

  // data pads come straight from the lane flops
  assign channel_one_serial_out_p = lane_data_p[0];
  assign channel_one_serial_out_n = lane_data_n[0];
  assign channel_two_serial_out_p = lane_data_p[1];
  assign channel_two_serial_out_n = lane_data_n[1];

  // echo positive leg: one flop after the synchroniser, so it leads the data by one ref_clk
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      echo_clock_out_p <= 1'b0;
    end else begin
      echo_clock_out_p <= echo_enable & sck_level;
    end
  end

  // echo negative leg, low single-ended like the pull-down
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      echo_clock_out_n <= 1'b0;
    end else begin
      echo_clock_out_n <= diff_mode & ~sck_level;
    end
  end

  // idle strobe count: up on strobe rise, cleared on readout rise;
  // a readout rise in the same cycle wins so activity always blocks nap
  always_comb begin
    next_idle_pulses = idle_pulses;
    if (sck_rise) begin
      next_idle_pulses = '0;
    end else if (cnv_rise) begin
      if (idle_pulses == dadc_pkg::PULSES_TO_WAKE) begin
        next_idle_pulses = 3'h1;
      end else begin
        next_idle_pulses = idle_pulses + 3'h1;
      end
    end
  end

  // count register; wraps after the waking strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idle_pulses <= '0;
    end else begin
      idle_pulses <= next_idle_pulses;
    end
  end

  // power state follows the idle strobe count
  always_comb begin
    next_power = power;
    case (power)
      dadc_pkg::DADC_OPER: begin
        if (cnv_rise && !sck_rise && next_idle_pulses == dadc_pkg::PULSES_TO_NAP) begin
          next_power = dadc_pkg::DADC_NAP;
        end
      end
      dadc_pkg::DADC_NAP: begin
        if (sck_rise) begin
          next_power = dadc_pkg::DADC_OPER;
        end else if (cnv_rise && next_idle_pulses == dadc_pkg::PULSES_TO_SLEEP) begin
          next_power = dadc_pkg::DADC_SLEEP;
        end
      end
      dadc_pkg::DADC_SLEEP: begin
        if (sck_rise && !diff_mode) begin
          next_power = dadc_pkg::DADC_OPER;
        end else if (cnv_rise && next_idle_pulses == dadc_pkg::PULSES_TO_WAKE) begin
          next_power = dadc_pkg::DADC_OPER;
        end
      end
      default: begin
        next_power = dadc_pkg::DADC_OPER;
      end
    endcase
  end

  // the host's wake-up wait after sleep is not timed here
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power <= dadc_pkg::DADC_OPER;
    end else begin
      power <= next_power;
    end
  end

  // status levels decode the next state, so they move with the state flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nap_active <= 1'b0;
    end else begin
      nap_active <= (next_power == dadc_pkg::DADC_NAP);
    end
  end

  // sleep level, same timing as the nap level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_active <= 1'b0;
    end else begin
      sleep_active <= (next_power == dadc_pkg::DADC_SLEEP);
    end
  end

endmodule : dadc_core

// ### hw/dadc_pkg.sv
// Purpose: shared constants for the dual converter readout and power control
// Assumes: one 10 MHz ref_clk; the readout clock and strobe arrive as pins
// Notes: result width is the converter's 14 bits plus sign
package dadc_pkg;

  localparam int unsigned RESULT_W = 15;
  localparam int unsigned BIT_CNT_W = 4;
  localparam int unsigned PULSE_CNT_W = 3;
  // strobe pulses counted with the readout clock idle
  localparam logic [2:0] PULSES_TO_NAP = 3'h2;
  localparam logic [2:0] PULSES_TO_SLEEP = 3'h4;
  localparam logic [2:0] PULSES_TO_WAKE = 3'h5;
  // reset values
  localparam logic [14:0] RESULT_RESET = 15'h0000;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  // interface select pin level for differential mode
  localparam logic IFACE_DIFF = 1'b1;

  // power states, one-hot
  typedef enum logic [2:0] {
    DADC_OPER = 3'h1,
    DADC_NAP = 3'h2,
    DADC_SLEEP = 3'h4
  } dadc_power_e;

endpackage : dadc_pkg

// ### hw/dadc_sync.sv
// Purpose: two-stage synchroniser plus edge detection for one pin
// Assumes: d comes from outside the ref_clk domain
// Notes: only the second stage and its delayed copy feed the edge logic
module dadc_sync (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic d,
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1;
  logic stage2;
  logic stage3;

  // first stage is read by the second stage only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise = stage2 & ~stage3;
  assign fall = ~stage2 & stage3;

endmodule : dadc_sync

// ### tb/dadc_core_properties.sv
// Purpose: port timing checks for the readout and power control
// Assumes: pins pass two sync flops and an output register
// Notes: windows allow for that latency
module dadc_core_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic convert_strobe,
  input wire logic readout_clk_p,
  input wire logic iface_select,
  input wire logic echo_clock_n_tied,
  input wire logic channel_one_serial_out_p,
  input wire logic channel_one_serial_out_n,
  input wire logic channel_two_serial_out_p,
  input wire logic channel_two_serial_out_n,
  input wire logic echo_clock_out_p,
  input wire logic echo_clock_out_n,
  input wire logic convert_start,
  input wire logic sample_track,
  input wire logic nap_active,
  input wire logic sleep_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // mode held long enough to pass the synchroniser
  sequence s_single;
    (!iface_select)[*6];
  endsequence
  sequence s_diff;
    iface_select[*6];
  endsequence
  start_one_pulse_a: assert property ($fell(convert_strobe) |-> ##[2:5] convert_start ##1 !convert_start)
    else $error("start pulse wrong");
  track_on_rise_a: assert property ($rose(convert_strobe) |-> ##[2:5] sample_track)
    else $error("sampler not tracking");
  hold_on_fall_a: assert property ($fell(convert_strobe) |-> ##[2:5] !sample_track)
    else $error("sampler not holding");
  nap_at_rise_a: assert property ($rose(nap_active) |-> $past(convert_strobe, 2))
    else $error("nap without strobe high");
  nap_clock_wake_a: assert property (s_single ##0 (nap_active && $rose(readout_clk_p)) |-> ##[2:6] !nap_active)
    else $error("nap kept after clock");
  sleep_clock_wake_a: assert property (s_single ##0 (sleep_active && $rose(readout_clk_p)) |-> ##[2:6] !sleep_active)
    else $error("sleep kept after clock");
  echo_disabled_a: assert property ((!iface_select && echo_clock_n_tied)[*6] |-> !echo_clock_out_p)
    else $error("echo not disabled");
  echo_follows_a: assert property ((!iface_select && !echo_clock_n_tied)[*6] ##0 $rose(readout_clk_p)
    |-> ##[1:5] echo_clock_out_p)
    else $error("echo missing");
  neg_legs_low_a: assert property (s_single |-> !channel_one_serial_out_n && !channel_two_serial_out_n
    && !echo_clock_out_n)
    else $error("negative leg driven");
  diff_pairs_a: assert property (s_diff |-> (channel_one_serial_out_n != channel_one_serial_out_p)
    && (channel_two_serial_out_n != channel_two_serial_out_p)
    && (echo_clock_out_n != echo_clock_out_p))
    else $error("pair not complementary");
endmodule : dadc_core_props

bind dadc_core dadc_core_props i_dadc_core_props (.ref_clk, .rstn, .convert_strobe, .readout_clk_p, .iface_select,
  .echo_clock_n_tied, .channel_one_serial_out_p, .channel_one_serial_out_n, .channel_two_serial_out_p,
  .channel_two_serial_out_n, .echo_clock_out_p, .echo_clock_out_n, .convert_start, .sample_track, .nap_active,
  .sleep_active);

// ### tb/dadc_core_tb_top.sv
// Purpose: self-checking bench for the readout and power control
// Assumes: host model paces strobe and an 800 ns readout clock
// Notes: all waits are fixed model timings
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module dadc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic iface_select = 1'b0;
  logic echo_clock_n_tied = 1'b0;
  logic results_valid = 1'b0;
  logic [14:0] chan_one_result = 15'h0000;
  logic [14:0] chan_two_result = 15'h0000;
  logic convert_strobe, readout_clk_p, readout_clk_n, sample_track, convert_start, nap_active, sleep_active;
  logic channel_one_serial_out_p, channel_one_serial_out_n, channel_two_serial_out_p, channel_two_serial_out_n;
  logic echo_clock_out_p, echo_clock_out_n;
  logic [14:0] got_one, got_two;
  logic [7:1] nap_tbl = 7'h46;
  logic [7:1] slp_tbl = 7'h08;
  int error_cnt = 0;
  int checked = 0;
  // free-running reference
  always #50 ref_clk = ~ref_clk;
  dadc_core i_dadc_core (.ref_clk, .rstn, .convert_strobe, .readout_clk_p, .readout_clk_n, .iface_select,
    .echo_clock_n_tied, .chan_one_result, .chan_two_result, .results_valid, .channel_one_serial_out_p,
    .channel_one_serial_out_n, .channel_two_serial_out_p, .channel_two_serial_out_n, .echo_clock_out_p,
    .echo_clock_out_n, .sample_track, .convert_start, .nap_active, .sleep_active);
  dadc_host_model i_dadc_host_model (.ref_clk, .iface_select, .data_one(channel_one_serial_out_p),
    .data_two(channel_two_serial_out_p), .convert_strobe, .readout_clk_p, .readout_clk_n);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // mode pins change, then settle through the synchroniser
  task automatic set_mode(input logic diff, input logic tied);
    @(posedge ref_clk);
    #1 iface_select = diff;
    echo_clock_n_tied = tied;
    repeat (8) @(posedge ref_clk);
  endtask : set_mode
  task automatic expect_state(input string nm, input logic nap, input logic slp);
    string nap_nm;
    string slp_nm;
    nap_nm = {nm, " nap"};
    slp_nm = {nm, " sleep"};
    `CHECK(nap_nm, nap, nap_active)
    `CHECK(slp_nm, slp, sleep_active)
  endtask : expect_state
  // one-cycle hand-over of a finished conversion
  task automatic load(input logic [14:0] a, input logic [14:0] b);
    @(posedge ref_clk);
    #1 results_valid = 1'b1;
    chan_one_result = a;
    chan_two_result = b;
    @(posedge ref_clk);
    #1 results_valid = 1'b0;
  endtask : load
  // the newer word loaded after the strobe must not leak into this frame
  task automatic test_readout();
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0], 1'b0);
      load(15'h5a3c, 15'h2b6d);
      i_dadc_host_model.strobe_pulse();
      load(15'h7fff, 15'h0000);
      i_dadc_host_model.read_frame(got_one, got_two);
      `CHECK("word one", 15'h5a3c, got_one)
      `CHECK("word two", 15'h2b6d, got_two)
      expect_state("read", 1'b0, 1'b0);
    end
    $display("test_readout done");
  endtask : test_readout
  // two idle strobes nap, one rise wakes, the count starts over
  task automatic test_nap();
    set_mode(1'b0, 1'b1);
    i_dadc_host_model.strobe_pulse();
    i_dadc_host_model.strobe_pulse();
    expect_state("two pulses", 1'b1, 1'b0);
    i_dadc_host_model.clk_cycle();
    expect_state("clock wake", 1'b0, 1'b0);
    i_dadc_host_model.strobe_pulse();
    expect_state("after wake", 1'b0, 1'b0);
    i_dadc_host_model.clk_cycle();
    $display("test_nap done");
  endtask : test_nap
  // idle strobes walk oper, nap, sleep, oper and on, in both modes
  task automatic test_cycle();
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0], 1'b0);
      for (int p = 1; p <= 7; p++) begin
        i_dadc_host_model.strobe_pulse();
        expect_state("cycle", nap_tbl[p], slp_tbl[p]);
      end
      i_dadc_host_model.clk_cycle();
    end
    $display("test_cycle done");
  endtask : test_cycle
  // a rise leaves sleep only single-ended; a reset mid-run clears it
  task automatic test_sleep_clock();
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0], 1'b0);
      repeat (4) i_dadc_host_model.strobe_pulse();
      i_dadc_host_model.clk_cycle(); // no result trusted after this wake
      expect_state("clock in sleep", 1'b0, m[0]);
    end
    set_mode(1'b0, 1'b0);
    #1 rstn = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
    expect_state("reset", 1'b0, 1'b0);
    // the count must restart from zero: one strobe stays awake, two nap
    i_dadc_host_model.strobe_pulse();
    expect_state("first after reset", 1'b0, 1'b0);
    i_dadc_host_model.strobe_pulse();
    expect_state("second after reset", 1'b1, 1'b0);
    i_dadc_host_model.clk_cycle();
    $display("test_sleep_clock done");
  endtask : test_sleep_clock
  // reset ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
    test_readout(); // rstn stands in for the power-on event here
    test_nap();
    test_cycle();
    test_sleep_clock();
    tally_and_finish();
  end
endmodule : dadc_core_tb_top

// ### tb/dadc_host_model.sv
// Purpose: host that paces strobe and readout clock and samples data
// Assumes: calls start from the bench right after a ref_clk edge
// Notes: readout clock stands still low between frames
module dadc_host_model (
  input wire logic ref_clk,
  input wire logic iface_select,
  input wire logic data_one,
  input wire logic data_two,
  output logic convert_strobe,
  output logic readout_clk_p,
  output logic readout_clk_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // single-ended leaves the negative leg at its pull-down level
  assign readout_clk_n = iface_select & ~readout_clk_p;
  initial begin
    convert_strobe = 1'b0;
    readout_clk_p = 1'b0;
  end
  // both phases far above the minimum width
  task automatic strobe_pulse();
    @(posedge ref_clk);
    #1 convert_strobe = 1'b1;
    #800 convert_strobe = 1'b0;
    #800;
  endtask : strobe_pulse
  // slow readout clock: lower throughput, same protocol
  task automatic clk_cycle();
    @(posedge ref_clk);
    #1 readout_clk_p = 1'b1;
    #400 readout_clk_p = 1'b0;
    #400;
  endtask : clk_cycle
  // sample each bit just before the next rising edge, msb first
  task automatic read_frame(output logic [14:0] w1, output logic [14:0] w2);
    for (int i = 14; i >= 0; i--) begin
      w1[i] = data_one;
      w2[i] = data_two;
      clk_cycle();
    end
  endtask : read_frame
endmodule : dadc_host_model
